// file: src/tfc_device.sv
`default_nettype none
// Notes on behaviour
// - Host fetches the group base address first.
// - Register address is base plus fixed offset.
// - Host accesses use absolute addresses, not offsets.
// - Touch accepted only below the detect level raised by sensitivity steps.
// - Higher sensitivity accepts lighter touches.
// - Speed at or above limit counts fast.
// - Fast motion averages the fast sample count.
// - Host should program fast count 4, 8, 16.
// - Slow motion averages the slow sample count.
// - Fast motion uses the fast precision level.
// - Slow motion uses the slow precision level.
// - More samples averaged means fewer reports.
// - Restore key reloads defaults after power cycle.
module tfc_device #(
  parameter logic [7:0] BASE_ADDR = 8'h20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic nv_blank,
  tfc_link_if.device link,
  input wire logic sample_valid,
  input wire logic [tfc_pkg::COORD_W-1:0] sample_x,
  input wire logic [tfc_pkg::COORD_W-1:0] sample_y,
  input wire logic [7:0] sample_pressure,
  input wire logic [7:0] sample_speed,
  output logic touch_valid,
  output logic touch_down,
  output logic touch_fast,
  output logic [tfc_pkg::COORD_W-1:0] touch_x,
  output logic [tfc_pkg::COORD_W-1:0] touch_y
);
  import tfc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CFG_LAST:0][7:0] cfg;
    logic restore_pending;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [1:0][ACC_W-1:0] acc;
    logic [7:0] nsamp;
    logic win_fast;
    logic down;
    logic feed;
    logic restart;
    logic [7:0] level;
    logic [1:0][COORD_W-1:0] feed_val;
    logic rep_down;
    logic rep_fast;
  } tfc_dev_state_t;

  tfc_dev_state_t q;
  tfc_dev_state_t next_q;
  tfc_dev_state_t reset_q;

  logic take;
  logic hit;
  logic [7:0] rel;
  logic [7:0] sens;
  logic [11:0] thr;
  logic touching;
  logic cls_fast;
  logic [7:0] cnt;
  logic [7:0] n_after;
  logic [1:0][ACC_W-1:0] sum;
  logic [1:0][COORD_W-1:0] samp;
  logic [1:0][COORD_W-1:0] sm_out;
  logic [1:0] sm_valid;

  // ----------------------------------------------------------------
  // Link requests and register file
  // ----------------------------------------------------------------
  assign take = link.req_valid & q.req_ready;
  assign rel = link.req_addr - BASE_ADDR;
  assign hit = (link.req_addr >= BASE_ADDR) && (rel <= OFS_LAST);

  // ----------------------------------------------------------------
  // Touch qualification and averaging window
  // ----------------------------------------------------------------
  // Sensitivity raises the effective detect level, so lighter touches pass.
  always_comb
  begin
    sens = (q.cfg[OFS_SENS] > SENS_MAX) ? SENS_MAX : q.cfg[OFS_SENS];
    thr = {4'h0, q.cfg[OFS_DETECT]} + 12'(sens * SENS_STEP);
    touching = ({4'h0, sample_pressure} < thr);
    cls_fast = (q.nsamp == '0) ? (sample_speed >= q.cfg[OFS_SPEED]) : q.win_fast;
    cnt = cls_fast ? q.cfg[OFS_FAST_AVG] : q.cfg[OFS_SLOW_AVG];
    if (cnt == '0)
      cnt = AVG_MIN;
    n_after = q.nsamp + AVG_MIN;
    samp[0] = sample_x;
    samp[1] = sample_y;
    for (int k = 0; k < 2; k++)
    begin
      sum[k] = ((q.nsamp == '0) ? '0 : q.acc[k]) + ACC_W'(samp[k]);
    end
  end

  // Next-state logic for link, registers and measurement path.
  always_comb
  begin
    next_q = q;
    next_q.rsp_valid = take;
    next_q.req_ready = ~take;
    next_q.feed = 1'b0;
    // Report flags take the decision of the window that fed the filters.
    if (q.feed)
    begin
      next_q.rep_down = q.down;
      next_q.rep_fast = q.win_fast;
    end
    if (take)
    begin
      unique case (link.req_op)
        TFC_OP_START: next_q.rsp_data = BASE_ADDR;
        TFC_OP_READ:
        begin
          next_q.rsp_data = 8'h00;
          if (hit)
          begin
            if (rel == OFS_SPECIAL0)
              next_q.rsp_data = SPECIAL0_VALUE;
            else if (rel == OFS_RESTORE)
              next_q.rsp_data = SPECIAL1_VALUE;
            else if (tfc_writable(rel))
              next_q.rsp_data = q.cfg[rel[4:0]];
            else
              next_q.rsp_data = tfc_cfg_default(rel);
          end
        end
        TFC_OP_WRITE:
        begin
          next_q.rsp_data = ACK_VALUE;
          if (hit && tfc_writable(rel))
            next_q.cfg[rel[4:0]] = link.req_wdata;
          if (hit && (rel == OFS_RESTORE) && (link.req_wdata == RESTORE_KEY))
            next_q.restore_pending = 1'b1;
        end
        default: next_q.rsp_data = ACK_VALUE;
      endcase
    end
    // A window closes only after cnt samples, so reports slow as cnt grows.
    if (sample_valid && touching)
    begin
      next_q.acc = sum;
      next_q.win_fast = cls_fast;
      if (n_after >= cnt)
      begin
        next_q.nsamp = '0;
        next_q.feed = 1'b1;
        next_q.restart = ~q.down;
        next_q.down = 1'b1;
        next_q.level = cls_fast ? q.cfg[OFS_FAST_PREC] : q.cfg[OFS_SLOW_PREC];
        for (int k = 0; k < 2; k++)
        begin
          next_q.feed_val[k] = COORD_W'(sum[k] >> tfc_log2(cnt));
        end
      end
      else
      begin
        next_q.nsamp = n_after;
      end
    end
    else if (sample_valid)
    begin
      // Lift-off drops the partial window and reports pen-up once.
      next_q.nsamp = '0;
      if (q.down)
      begin
        next_q.down = 1'b0;
        next_q.feed = 1'b1;
        next_q.restart = 1'b1;
        next_q.feed_val = sm_out;
      end
    end
  end

  // Reset keeps stored settings unless storage is blank or a restore is due.
  always_comb
  begin
    reset_q = '0;
    reset_q.req_ready = 1'b1;
    for (int i = 0; i <= CFG_LAST; i++)
    begin
      if (nv_blank || q.restore_pending)
        reset_q.cfg[i] = tfc_cfg_default(8'(i));
      else
        reset_q.cfg[i] = q.cfg[i];
    end
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= reset_q;
    else if (ce)
      q <= next_q;
  end

  // ----------------------------------------------------------------
  // Accuracy filters, one per axis
  // ----------------------------------------------------------------
  for (genvar k = 0; k < 2; k++)
  begin : g_axis
    tfc_smoother u_smoother (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .in_valid(q.feed),
      .restart(q.restart),
      .level(q.level),
      .in_value(q.feed_val[k]),
      .out_valid(sm_valid[k]),
      .out_value(sm_out[k])
    );
  end

  assign touch_valid = sm_valid[0];
  assign touch_down = q.rep_down;
  assign touch_fast = q.rep_fast;
  assign touch_x = sm_out[0];
  assign touch_y = sm_out[1];
  assign link.req_ready = q.req_ready;
  assign link.rsp_valid = q.rsp_valid;
  assign link.rsp_data = q.rsp_data;

endmodule : tfc_device
`default_nettype wire

// file: src/tfc_host.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
// Host controller: AXI4-Lite registers in, link commands out.
module tfc_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  tfc_link_if.host link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import tfc_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_BASE_REQ, H_BASE_WAIT, H_CMD_REQ, H_CMD_WAIT} tfc_fsm_t;

  typedef struct packed {
    tfc_fsm_t fsm;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] cmd;
    logic base_known;
    logic [7:0] base;
    logic [7:0] rd_byte;
    logic unusual;
    logic req_valid;
    tfc_op_t req_op;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
  } tfc_host_state_t;

  tfc_host_state_t q;
  tfc_host_state_t next_q;
  logic [31:0] merged;
  logic [31:0] status;
  logic commit;

  // ----------------------------------------------------------------
  // Register bus and command sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    merged = q.cmd;
    for (int b = 0; b < 4; b++)
    begin
      if (q.w_strb[b])
        merged[b*8 +: 8] = q.w_data[b*8 +: 8];
    end
    status = '0;
    status[ST_BUSY] = (q.fsm != H_IDLE);
    status[ST_BASE] = q.base_known;
    status[ST_UNUSUAL] = q.unusual;
    status[ST_RDATA_LSB +: 8] = q.rd_byte;
    commit = q.aw_held && q.w_held && !q.bvalid;
    // Address and data are caught independently, in either order.
    if (s_axi_awvalid && q.awready)
    begin
      next_q.aw_held = 1'b1;
      next_q.awready = 1'b0;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      next_q.w_held = 1'b1;
      next_q.wready = 1'b0;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      next_q.bvalid = 1'b0;
    if (commit)
    begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      unique case (q.aw_addr)
        HOST_CMD:
        begin
          // A command written while busy is dropped.
          if (q.fsm == H_IDLE)
          begin
            next_q.cmd = merged;
            next_q.req_valid = 1'b1;
            next_q.req_wdata = merged[CMD_WDATA_LSB +: 8];
            next_q.req_op = merged[CMD_WRITE_BIT] ? TFC_OP_WRITE : TFC_OP_READ;
            next_q.req_addr = q.base + merged[CMD_OFS_LSB +: 8];
            next_q.fsm = H_CMD_REQ;
            if (!q.base_known)
            begin
              next_q.req_op = TFC_OP_START;
              next_q.req_addr = '0;
              next_q.fsm = H_BASE_REQ;
            end
            if (merged[CMD_WRITE_BIT] && (merged[CMD_OFS_LSB +: 8] == OFS_FAST_AVG))
              next_q.unusual = !(merged[CMD_WDATA_LSB +: 8] inside {REC_AVG_A, REC_AVG_B,
                                 REC_AVG_C});
          end
        end
        HOST_STATUS, HOST_BASE: next_q.bresp = RESP_OKAY;
        default: next_q.bresp = RESP_SLVERR;
      endcase
    end
    // Reads answer the cycle after the address is taken.
    if (q.rvalid && s_axi_rready)
    begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready)
    begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        HOST_CMD: next_q.rdata = q.cmd;
        HOST_STATUS: next_q.rdata = status;
        HOST_BASE: next_q.rdata = {24'h000000, q.base};
        default:
        begin
          next_q.rdata = '0;
          next_q.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Link sequencing.
    unique case (q.fsm)
      H_IDLE: ;
      H_BASE_REQ, H_CMD_REQ:
      begin
        if (link.req_ready)
        begin
          next_q.req_valid = 1'b0;
          next_q.fsm = (q.fsm == H_BASE_REQ) ? H_BASE_WAIT : H_CMD_WAIT;
        end
      end
      H_BASE_WAIT:
      begin
        if (link.rsp_valid)
        begin
          next_q.base = link.rsp_data;
          next_q.base_known = 1'b1;
          next_q.req_valid = 1'b1;
          next_q.req_op = q.cmd[CMD_WRITE_BIT] ? TFC_OP_WRITE : TFC_OP_READ;
          next_q.req_addr = link.rsp_data + q.cmd[CMD_OFS_LSB +: 8];
          next_q.fsm = H_CMD_REQ;
        end
      end
      H_CMD_WAIT:
      begin
        if (link.rsp_valid)
        begin
          if (q.req_op == TFC_OP_READ)
            next_q.rd_byte = link.rsp_data;
          next_q.fsm = H_IDLE;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end
    else if (ce)
    begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign link.req_valid = q.req_valid;
  assign link.req_op = q.req_op;
  assign link.req_addr = q.req_addr;
  assign link.req_wdata = q.req_wdata;

endmodule : tfc_host
`default_nettype wire

// file: src/tfc_link_if.sv
`default_nettype none
// Command link between the host controller and the touch device.
interface tfc_link_if;
  logic req_valid;
  logic req_ready;
  tfc_pkg::tfc_op_t req_op;
  logic [tfc_pkg::ADDR_W-1:0] req_addr;
  logic [7:0] req_wdata;
  logic rsp_valid;
  logic [7:0] rsp_data;

  modport device (
    input req_valid, req_op, req_addr, req_wdata,
    output req_ready, rsp_valid, rsp_data
  );
  modport host (
    output req_valid, req_op, req_addr, req_wdata,
    input req_ready, rsp_valid, rsp_data
  );
endinterface : tfc_link_if
`default_nettype wire

// file: src/tfc_pkg.sv
`default_nettype none
package tfc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int COORD_W = 12;
  localparam int ACC_W = 19;
  localparam int CFG_LAST = 18;

  // Link commands.
  typedef enum logic [1:0] {TFC_OP_START, TFC_OP_READ, TFC_OP_WRITE} tfc_op_t;

  // ----------------------------------------------------------------
  // Configuration offsets from the group base
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SPECIAL0 = 8'h00;
  localparam logic [7:0] OFS_RESTORE = 8'h01;
  localparam logic [7:0] OFS_DETECT = 8'h02;
  localparam logic [7:0] OFS_SENS = 8'h03;
  localparam logic [7:0] OFS_FAST_AVG = 8'h04;
  localparam logic [7:0] OFS_SLOW_AVG = 8'h05;
  localparam logic [7:0] OFS_FAST_PREC = 8'h06;
  localparam logic [7:0] OFS_SLOW_PREC = 8'h07;
  localparam logic [7:0] OFS_SPEED = 8'h08;
  localparam logic [7:0] OFS_HOLD = 8'h0F;
  localparam logic [7:0] OFS_SPECIAL_A = 8'h10;
  localparam logic [7:0] OFS_PAUSE = 8'h11;
  localparam logic [7:0] OFS_SPECIAL_B = 8'h12;
  localparam logic [7:0] OFS_LAST = 8'h12;

  // Fixed read values, restore key, ack value and limits.
  localparam logic [7:0] SPECIAL0_VALUE = 8'h58;
  localparam logic [7:0] SPECIAL1_VALUE = 8'h01;
  localparam logic [7:0] RESTORE_KEY = 8'hFF;
  localparam logic [7:0] ACK_VALUE = 8'h00;
  localparam logic [7:0] SENS_MAX = 8'h0A;
  localparam logic [7:0] SENS_STEP = 8'h08;
  localparam logic [7:0] AVG_MIN = 8'h01;
  localparam logic [7:0] LEVEL_MIN = 8'h01;
  localparam logic [7:0] LEVEL_MAX = 8'h08;

  // Default contents of each configuration slot.
  function automatic logic [7:0] tfc_cfg_default(input logic [7:0] ofs);
    unique case (ofs)
      OFS_DETECT: return 8'hC5;
      OFS_SENS: return 8'h04;
      OFS_FAST_AVG: return 8'h04;
      OFS_SLOW_AVG: return 8'h10;
      OFS_FAST_PREC: return 8'h04;
      OFS_SLOW_PREC: return 8'h08;
      OFS_SPEED: return 8'h04;
      OFS_HOLD: return 8'hC8;
      OFS_SPECIAL_A: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : tfc_cfg_default

  // True where a link write stores a value.
  function automatic logic tfc_writable(input logic [7:0] ofs);
    return ((ofs >= OFS_DETECT) && (ofs <= OFS_SPEED)) || (ofs == OFS_HOLD) ||
           (ofs == OFS_SPECIAL_A) || (ofs == OFS_SPECIAL_B);
  endfunction : tfc_writable

  // Position of the highest set bit, used as an averaging shift.
  function automatic logic [2:0] tfc_log2(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (v[i])
      begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : tfc_log2

  // ----------------------------------------------------------------
  // Host controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_BASE = 8'h08;
  localparam int CMD_OFS_LSB = 0;
  localparam int CMD_WDATA_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_BASE = 1;
  localparam int ST_UNUSUAL = 2;
  localparam int ST_RDATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] REC_AVG_A = 8'h04;
  localparam logic [7:0] REC_AVG_B = 8'h08;
  localparam logic [7:0] REC_AVG_C = 8'h10;

endpackage : tfc_pkg
`default_nettype wire

// file: src/tfc_smoother.sv
`default_nettype none
// Accuracy filter: first-order smoothing whose strength follows the level.
module tfc_smoother (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic restart,
  input wire logic [7:0] level,
  input wire logic [tfc_pkg::COORD_W-1:0] in_value,
  output logic out_valid,
  output logic [tfc_pkg::COORD_W-1:0] out_value
);
  import tfc_pkg::*;

  typedef struct packed {
    logic valid;
    logic [COORD_W-1:0] value;
  } tfc_sm_state_t;

  tfc_sm_state_t q;
  tfc_sm_state_t next_q;
  logic [2:0] shift;
  logic signed [COORD_W:0] diff;
  logic signed [COORD_W:0] step;

  // Level 1 passes samples through; each step up to level 8 halves the gain.
  always_comb
  begin
    next_q = q;
    next_q.valid = 1'b0;
    if (level <= LEVEL_MIN)
      shift = 3'h0;
    else if (level >= LEVEL_MAX)
      shift = 3'(LEVEL_MAX - LEVEL_MIN);
    else
      shift = 3'(level - LEVEL_MIN);
    diff = $signed({1'b0, in_value}) - $signed({1'b0, q.value});
    step = diff >>> shift;
    if (in_valid)
    begin
      next_q.valid = 1'b1;
      if (restart)
        next_q.value = in_value;
      else
        next_q.value = q.value + step[COORD_W-1:0];
    end
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else if (ce)
      q <= next_q;
  end

  assign out_valid = q.valid;
  assign out_value = q.value;

endmodule : tfc_smoother
`default_nettype wire

// file: test/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tfc_pkg::*;

  localparam logic [7:0] BASE = 8'h20;
  localparam logic [7:0] OFS_T [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h0F, 8'h10, 8'h11, 8'h12};
  localparam logic [7:0] DEF_T [13] = '{8'h58, 8'h01, 8'hC5, 8'h04, 8'h04, 8'h10, 8'h04,
    8'h08, 8'h04, 8'hC8, 8'h03, 8'h00, 8'h00};
  logic aclk, aresetn, ce, nv_blank, sample_valid, touch_valid, touch_down, touch_fast;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sample_pressure, sample_speed;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] sample_x, sample_y, touch_x, touch_y;
  logic [67:0] rd_q[$], tc_q[$];
  int errors, n_checks;

  tfc_link_if tfc_link_if_i ();
  tfc_host tfc_host_i (.link(tfc_link_if_i), .*);
  tfc_device #(.BASE_ADDR(BASE)) tfc_device_i (.link(tfc_link_if_i), .*);
  tfc_link_checker #(.BASE_ADDR(BASE)) tfc_link_checker_i (.aclk, .aresetn,
    .req_valid(tfc_link_if_i.req_valid), .req_ready(tfc_link_if_i.req_ready),
    .req_op(tfc_link_if_i.req_op), .req_addr(tfc_link_if_i.req_addr),
    .req_wdata(tfc_link_if_i.req_wdata), .rsp_valid(tfc_link_if_i.rsp_valid),
    .rsp_data(tfc_link_if_i.rsp_data));

  // Free-running 100 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Compares the masked bits of a result with its note.
  task automatic compare(input logic [33:0] got, input logic [67:0] em);
    n_checks++;
    if (((got ^ em[67:34]) & em[33:0]) !== 34'h0)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got & em[33:0], em[67:34]);
    end
  endtask : compare

  // Takes the oldest note whenever a bus answer or a touch report appears.
  always @(posedge aclk)
  begin
    if (aresetn && s_axi_rvalid && s_axi_rready)
      compare({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    if (aresetn && s_axi_bvalid && s_axi_bready)
      compare({s_axi_bresp, 32'h0}, rd_q.pop_front());
    if (aresetn && touch_valid)
      compare({8'h0, touch_down, touch_fast, touch_x, touch_y},
              tc_q.size() ? tc_q.pop_front() : '1);
  end

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    rd_q.push_back(68'h300000000);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m,
                     output logic [31:0] d);
    @(posedge aclk);
    rd_q.push_back({e, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axr

  // Issues one link command and polls status until the controller is idle.
  task automatic cmd(input logic [7:0] ofs, input logic [7:0] d, input logic wr);
    logic [31:0] st;
    axw(HOST_CMD, {15'h0, wr, d, ofs});
    st = 32'h1;
    for (int i = 0; i < 50 && st[ST_BUSY] !== 1'b0; i++)
      axr(HOST_STATUS, '0, '0, st);
  endtask : cmd

  task automatic rcfg(input logic [7:0] ofs, input logic [7:0] e);
    logic [31:0] st;
    cmd(ofs, 8'h00, 1'b0);
    axr(HOST_STATUS, {RESP_OKAY, 16'h0, e, 8'h02}, {2'h3, 16'h0, 8'hFF, 8'h03}, st);
  endtask : rcfg

  task automatic smp(input logic [7:0] p, input logic [7:0] sp, input logic [11:0] x,
                     input logic [11:0] y);
    @(posedge aclk);
    sample_valid <= 1'b1;
    sample_pressure <= p;
    sample_speed <= sp;
    sample_x <= x;
    sample_y <= y;
    @(posedge aclk);
    sample_valid <= 1'b0;
  endtask : smp

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Cuts a hang short after far longer than the tests need.
  initial
  begin
    #200us;
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [11:0] x0, y0, x1, y1, x2, y2;
    logic [12:0] ax, ay;
    {errors, n_checks} = '0;
    {aresetn, sample_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {sample_pressure, sample_speed, sample_x, sample_y} = '0;
    {ce, nv_blank, s_axi_wstrb} = 6'h3F;
    void'($urandom(6439));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 13; i++)
      rcfg(OFS_T[i], DEF_T[i]);
    $display("test defaults done");
    for (int i = 2; i < 13; i++)
    begin
      d = $urandom;
      cmd(OFS_T[i], d[7:0], 1'b1);
      rcfg(OFS_T[i], (i == 11) ? 8'h00 : d[7:0]);
    end
    rcfg(8'h13, 8'h00);
    axr(8'h0C, {RESP_SLVERR, 32'h0}, '1, d);
    $display("test readback done");
    cmd(OFS_FAST_AVG, 8'h10, 1'b1);
    axr(HOST_STATUS, 34'h0, 34'h4, d);
    cmd(OFS_FAST_AVG, 8'h01, 1'b1);
    axr(HOST_STATUS, 34'h4, 34'h4, d);
    $display("test recommendation done");
    cmd(OFS_DETECT, 8'h80, 1'b1);
    cmd(OFS_SENS, 8'h00, 1'b1);
    cmd(OFS_SLOW_AVG, 8'h02, 1'b1);
    cmd(OFS_FAST_PREC, 8'h01, 1'b1);
    cmd(OFS_SLOW_PREC, 8'h01, 1'b1);
    cmd(OFS_SPEED, 8'h40, 1'b1);
    {x0, y0, x1, y1, x2, y2} = 72'({$urandom, $urandom, $urandom});
    ax = (13'(x1) + 13'(x2)) >> 1;
    ay = (13'(y1) + 13'(y2)) >> 1;
    smp(8'h80, 8'h40, x0, y0);
    tc_q.push_back({8'h0, 2'b11, x0, y0, ~34'h0});
    smp(8'h7F, 8'h40, x0, y0);
    tc_q.push_back({8'h0, 2'b10, ax[11:0], ay[11:0], ~34'h0});
    smp(8'h7F, 8'h3F, x1, y1);
    smp(8'h7F, 8'h3F, x2, y2);
    tc_q.push_back({8'h0, 2'b00, ax[11:0], ay[11:0], 34'h3FEFFFFFF});
    smp(8'h90, 8'h40, x0, y0);
    cmd(OFS_SENS, 8'h01, 1'b1);
    tc_q.push_back({8'h0, 2'b11, x0, y0, ~34'h0});
    smp(8'h87, 8'h40, x0, y0);
    repeat (4) @(posedge aclk);
    $display("test touch path done");
    @(posedge aclk);
    aresetn <= 1'b0;
    nv_blank <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rcfg(OFS_SENS, 8'h01);
    cmd(OFS_RESTORE, 8'hFF, 1'b1);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rcfg(OFS_DETECT, 8'hC5);
    $display("test restore done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// file: test/tfc_link_checker.sv
`default_nettype none
// ----------------------------------------------------------------
// Link protocol checker
// ----------------------------------------------------------------
module tfc_link_checker #(
  parameter logic [7:0] BASE_ADDR = 8'h20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire tfc_pkg::tfc_op_t req_op,
  input wire logic [tfc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import tfc_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Remembers that the group base has been fetched since the last reset.
  logic seen_start;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seen_start <= 1'b0;
    else if (req_valid && req_ready && req_op == TFC_OP_START)
      seen_start <= 1'b1;
  end

  // A taken request and the single-cycle answer that must follow it.
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_strobe;
    rsp_valid ##1 !rsp_valid;
  endsequence

  property p_answer;
    s_take |=> s_strobe;
  endproperty
  a_answer: assert property (p_answer) else $error("link answer missing or too long");
  property p_no_stray;
    rsp_valid |-> $past(req_valid) && $past(req_ready);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("link answer without request");
  property p_gap;
    s_take |=> !req_ready ##1 req_ready;
  endproperty
  a_gap: assert property (p_gap) else $error("link ready gap wrong");
  property p_wait;
    s_take |=> !req_valid;
  endproperty
  a_wait: assert property (p_wait) else $error("host did not wait for answer");
  property p_base;
    req_valid && req_ready && req_op == TFC_OP_START |=> rsp_data == BASE_ADDR;
  endproperty
  a_base: assert property (p_base) else $error("start answer is not the base");
  property p_ack;
    req_valid && req_ready && req_op == TFC_OP_WRITE |=> rsp_data == ACK_VALUE;
  endproperty
  a_ack: assert property (p_ack) else $error("write answer is not the ack");
  property p_first;
    req_valid && req_op != TFC_OP_START |-> seen_start;
  endproperty
  a_first: assert property (p_first) else $error("access before base fetch");
  property p_abs;
    req_valid && req_op != TFC_OP_START |-> req_addr >= BASE_ADDR;
  endproperty
  a_abs: assert property (p_abs) else $error("access below group base");
endmodule : tfc_link_checker
`default_nettype wire
